// >>> rtl/rdc_status_map.svh
`ifndef RDC_STATUS_MAP_SVH
`define RDC_STATUS_MAP_SVH

// Angle word width
`define ANGLE_W 12
// Error thresholds in angle LSBs (4096 per turn): 5 deg set, 1 deg release
`define TRACK_SET_LSB 12'd57
`define TRACK_CLR_LSB 12'd11
// Excitation phase step per clock for each select code (32-bit accumulator)
`define EXC_STEP_00 32'h0000_5000
`define EXC_STEP_01 32'h0000_6000
`define EXC_STEP_10 32'h0000_7800
`define EXC_STEP_11 32'h0000_a000
// Reset values
`define RST_FLAG_N 1'b1
`define RST_DIR 1'b1

`endif

// >>> rtl/rdc_status_pkg.sv
package rdc_status_pkg;

    // Fault class shown on the flag pair, in priority order
    typedef enum logic [1:0] {
        FAULT_NONE,
        FAULT_TRACK,
        FAULT_DEGRADE,
        FAULT_MISSING
    } fault_t;

endpackage : rdc_status_pkg

// >>> rtl/excite_nco.sv
`timescale 1ns/1ns
`include "rdc_status_map.svh"

module excite_nco
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Frequency select, already synchronised
    input wire logic [1:0] i_sel,
    // Excitation phase
    output logic [7:0] o_phase
);

    logic [31:0] acc_q;
    logic [31:0] step;

    always_comb
    begin
        case (i_sel)
            2'h0: step = `EXC_STEP_00;
            2'h1: step = `EXC_STEP_01;
            2'h2: step = `EXC_STEP_10;
            default: step = `EXC_STEP_11;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            acc_q <= 32'h0;
        else
            acc_q <= acc_q + step;
    end

    assign o_phase = acc_q[31:24];

endmodule : excite_nco

// >>> rtl/rdc_status_outputs.sv
// Behaviour
// - Quadrature output B runs freely from angle
// - Revolution marker driven continuously with encoder
// - Direction high while angle increases
// - Degradation flag low on overrange input
// - Overrange degradation follows condition, not held
// - Tracking fault low, clears when fault ends
// - Excitation frequency set by two selects
// - Flag pair encodes fault class by priority
// - Tracking fault hysteresis: set 5, clear 1
// - Mismatch degradation held until sample rising edge
`timescale 1ns/1ns
`include "rdc_status_map.svh"

module rdc_status_outputs
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Tracked angle and loop error from the tracking loop (same clock)
    input wire logic [11:0] i_angle,
    input wire logic [11:0] i_track_err,
    input wire logic i_rate_over,
    // Analog monitor comparator results (asynchronous)
    input wire logic i_input_over,
    input wire logic i_input_mismatch,
    input wire logic i_input_missing,
    // Host pins (asynchronous)
    input wire logic i_sample,
    input wire logic i_excite_freq_sel_0,
    input wire logic i_excite_freq_sel_1,
    // Encoder emulation
    output logic o_quad_a,
    output logic o_quad_b,
    output logic o_revolution_marker,
    output logic o_direction,
    // Fault flags
    output logic o_degradation_flag_n,
    output logic o_tracking_fault_n,
    // Excitation phase to the sine table
    output logic [7:0] o_excitation_out
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic sample_prev_q;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_q <= 6'h0;
            sync2_q <= 6'h0;
        end
        else
        begin
            sync1_q <= {i_input_over, i_input_mismatch, i_input_missing,
                        i_sample, i_excite_freq_sel_1, i_excite_freq_sel_0};
            sync2_q <= sync1_q;
        end
    end

    logic over_s;
    logic mism_s;
    logic miss_s;
    logic sample_s;
    logic sample_rise;
    assign over_s = sync2_q[5];
    assign mism_s = sync2_q[4];
    assign miss_s = sync2_q[3];
    assign sample_s = sync2_q[2];
    assign sample_rise = sample_s & ~sample_prev_q;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            sample_prev_q <= 1'b0;
        else
            sample_prev_q <= sample_s;
    end

    // ==========================================================
    // Excitation
    // ==========================================================
    logic [7:0] phase;

    excite_nco u_nco
    (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_sel(sync2_q[1:0]),
        .o_phase(phase)
    );

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            o_excitation_out <= 8'h0;
        else
            o_excitation_out <= phase;
    end

    // ==========================================================
    // Encoder emulation
    // ==========================================================
    logic [11:0] angle_prev_q;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            angle_prev_q <= 12'h0;
        else
            angle_prev_q <= i_angle;
    end

    // Gray of the two low bits gives A/B a quarter cycle apart; the phase
    // order flips by itself when the angle counts down
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_quad_a <= 1'b0;
            o_quad_b <= 1'b0;
            o_revolution_marker <= 1'b0;
            o_direction <= `RST_DIR;
        end
        else
        begin
            o_quad_a <= i_angle[1];
            o_quad_b <= i_angle[1] ^ i_angle[0];
            o_revolution_marker <= (i_angle == 12'h0);
            // Modular step: a difference in the upper half means counting down
            if (i_angle != angle_prev_q)
                o_direction <= (12'(i_angle - angle_prev_q) <= 12'h7ff);
        end
    end

    // ==========================================================
    // Fault detection
    // ==========================================================
    logic track_q;
    logic mism_hold_q;
    logic miss_hold_q;
    logic [11:0] err_abs;
    assign err_abs = i_track_err[11] ? 12'(-i_track_err) : i_track_err;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            track_q <= 1'b0;
        else if (i_rate_over || err_abs > `TRACK_SET_LSB)
            track_q <= 1'b1;
        else if (err_abs < `TRACK_CLR_LSB)
            track_q <= 1'b0;
    end

    // Latched classes: a new event wins over a sample edge in the same cycle
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            mism_hold_q <= 1'b0;
            miss_hold_q <= 1'b0;
        end
        else
        begin
            if (mism_s)
                mism_hold_q <= 1'b1;
            else if (sample_rise)
                mism_hold_q <= 1'b0;
            if (miss_s)
                miss_hold_q <= 1'b1;
            else if (sample_rise)
                miss_hold_q <= 1'b0;
        end
    end

    rdc_status_pkg::fault_t fault;
    always_comb
    begin
        if (miss_hold_q)
            fault = rdc_status_pkg::FAULT_MISSING;
        else if (over_s || mism_hold_q)
            fault = rdc_status_pkg::FAULT_DEGRADE;
        else if (track_q)
            fault = rdc_status_pkg::FAULT_TRACK;
        else
            fault = rdc_status_pkg::FAULT_NONE;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_degradation_flag_n <= `RST_FLAG_N;
            o_tracking_fault_n <= `RST_FLAG_N;
        end
        else
        begin
            case (fault)
                rdc_status_pkg::FAULT_MISSING:
                begin
                    o_degradation_flag_n <= 1'b0;
                    o_tracking_fault_n <= 1'b0;
                end
                rdc_status_pkg::FAULT_DEGRADE:
                begin
                    o_degradation_flag_n <= 1'b0;
                    o_tracking_fault_n <= 1'b1;
                end
                rdc_status_pkg::FAULT_TRACK:
                begin
                    o_degradation_flag_n <= 1'b1;
                    o_tracking_fault_n <= 1'b0;
                end
                default:
                begin
                    o_degradation_flag_n <= 1'b1;
                    o_tracking_fault_n <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    a_quad_b_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_quad_b == ($past(i_angle[1]) ^ $past(i_angle[0])))
        else $error("quad b wrong");
    a_quad_a_follow: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_quad_a == $past(i_angle[1]))
        else $error("quad a wrong");
    a_marker_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_angle == 12'h0) |=> o_revolution_marker)
        else $error("marker missed");
    a_dir_up: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_angle == angle_prev_q + 12'h1) |=> o_direction)
        else $error("direction not high");
    a_degrade_over: assert property (@(posedge i_clk) disable iff (!i_nrst)
        over_s |=> !o_degradation_flag_n)
        else $error("degrade flag missing");
    a_degrade_release: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!over_s && !mism_hold_q && !miss_hold_q) |=> o_degradation_flag_n)
        else $error("degrade flag held");
    a_track_hyst: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (track_q && !i_rate_over && err_abs >= `TRACK_CLR_LSB
         && err_abs <= `TRACK_SET_LSB) |=> track_q)
        else $error("hysteresis lost");
    a_track_pin: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (track_q && !miss_hold_q && !over_s && !mism_hold_q) |=> !o_tracking_fault_n)
        else $error("tracking pin wrong");
    a_missing_pair: assert property (@(posedge i_clk) disable iff (!i_nrst)
        miss_hold_q |=> (!o_degradation_flag_n && !o_tracking_fault_n))
        else $error("missing pair wrong");
    a_mism_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (mism_hold_q && !sample_rise) |=> mism_hold_q)
        else $error("mismatch released early");
    a_excite_out: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_excitation_out == $past(phase))
        else $error("excitation stale");

    c_track_fault: cover property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(o_tracking_fault_n));
    c_mism_clear: cover property (@(posedge i_clk) disable iff (!i_nrst)
        mism_hold_q && sample_rise && !mism_s);
    c_dir_down: cover property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(o_direction));

endmodule : rdc_status_outputs

// >>> tb/resolver_model.sv
`timescale 1ns/1ns

// ==============================================================
// Tracking loop stand-in: holds the angle word and steps it on command
module resolver_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Commands
    input wire logic i_load,
    input wire logic [11:0] i_load_val,
    input wire logic i_up,
    input wire logic i_dn,
    // Angle
    output logic [11:0] o_angle
);
    // One LSB per clock at most when stepping, as a real loop moves; a load jumps straight to i_load_val
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_angle <= 12'h000;
        end
        else if (i_load)
        begin
            o_angle <= i_load_val;
        end
        else if (i_up)
        begin
            o_angle <= o_angle + 12'h001;
        end
        else if (i_dn)
        begin
            o_angle <= o_angle - 12'h001;
        end
    end
endmodule : resolver_model

// >>> tb/test_resolver_status_and_encoder_outputs.sv
`timescale 1ns/1ns
`include "rdc_status_map.svh"

module test_resolver_status_and_encoder_outputs;
    logic clk, nrst, ld, up, dn, rate, over, mism, miss, smp, fs0, fs1;
    logic [11:0] ld_val, ang, err;
    logic qa, qb, mark, dir, deg_n, trk_n;
    logic [7:0] excitation_out;
    int miscompares = 0;
    int n_tests = 0;

    resolver_model i_model (.i_clk(clk), .i_nrst(nrst), .i_load(ld), .i_load_val(ld_val),
        .i_up(up), .i_dn(dn), .o_angle(ang));

    rdc_status_outputs i_dut (.i_clk(clk), .i_nrst(nrst), .i_angle(ang), .i_track_err(err),
        .i_rate_over(rate), .i_input_over(over), .i_input_mismatch(mism),
        .i_input_missing(miss), .i_sample(smp), .i_excite_freq_sel_0(fs0),
        .i_excite_freq_sel_1(fs1), .o_quad_a(qa), .o_quad_b(qb),
        .o_revolution_marker(mark), .o_direction(dir), .o_degradation_flag_n(deg_n),
        .o_tracking_fault_n(trk_n), .o_excitation_out(excitation_out));

    // ==============================================================
    // Common tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // ==============================================================
    // Scenarios
    // One angle step per clock: exactly one of A and B may toggle per step
    task automatic run_enc(input logic exp_dir);
        logic [11:0] a;
        logic pa;
        logic pb;
        for (int i = 0; i < 24; i++)
        begin
            a = ang;
            pa = qa;
            pb = qb;
            tick(1);
            chk1(qa, a[1]);
            chk1(qb, a[1] ^ a[0]);
            chk1(mark, a == 12'h000);
            if (i > 1) chk1(dir, exp_dir);
            if (i > 0) chk1((qa ^ pa) ^ (qb ^ pb), 1'b1);
        end
    endtask : run_enc

    task automatic t_encoder;
        ld = 1'b1;
        ld_val = 12'hff8;
        tick(1);
        ld = 1'b0;
        up = 1'b1;
        run_enc(1'b1);
        up = 1'b0;
        dn = 1'b1;
        run_enc(1'b0);
        dn = 1'b0;
    endtask : t_encoder

    // Flag pair after the sync delay: expected degradation and tracking levels
    task automatic flags(input int n, input logic d, input logic t);
        tick(n);
        chk1(deg_n, d);
        chk1(trk_n, t);
    endtask : flags

    task automatic t_overrange;
        over = 1'b1;
        flags(3, 1'b0, 1'b1);
        over = 1'b0;
        flags(3, 1'b1, 1'b1);
    endtask : t_overrange

    // Latched classes reach the pins one cycle after the overrange level
    task automatic t_mismatch;
        mism = 1'b1;
        flags(4, 1'b0, 1'b1);
        mism = 1'b0;
        flags(6, 1'b0, 1'b1);
        smp = 1'b1;
        flags(4, 1'b1, 1'b1);
        smp = 1'b0;
    endtask : t_mismatch

    task automatic t_missing;
        miss = 1'b1;
        flags(4, 1'b0, 1'b0);
        smp = 1'b1;
        flags(4, 1'b0, 1'b0);
        smp = 1'b0;
        miss = 1'b0;
        flags(4, 1'b0, 1'b0);
        smp = 1'b1;
        flags(4, 1'b1, 1'b1);
        smp = 1'b0;
    endtask : t_missing

    task automatic t_track;
        err = 12'd57;
        flags(3, 1'b1, 1'b1);
        err = 12'd58;
        flags(3, 1'b1, 1'b0);
        err = 12'd20;
        flags(3, 1'b1, 1'b0);
        err = 12'd10;
        flags(3, 1'b1, 1'b1);
        rate = 1'b1;
        flags(3, 1'b1, 1'b0);
        rate = 1'b0;
        flags(3, 1'b1, 1'b1);
    endtask : t_track

    // Phase advance over 8192 clocks is an exact whole count of top-byte steps
    task automatic t_excite;
        logic [31:0] steps [4];
        logic [7:0] p0;
        logic [63:0] adv;
        steps = '{`EXC_STEP_00, `EXC_STEP_01, `EXC_STEP_10, `EXC_STEP_11};
        for (int i = 0; i < 4; i++)
        begin
            fs0 = i[0];
            fs1 = i[1];
            tick(8);
            p0 = excitation_out;
            adv = (64'(steps[i]) * 64'd8192) >> 24;
            tick(8192);
            chk8(excitation_out - p0, adv[7:0]);
        end
    endtask : t_excite

    // ==============================================================
    // Clock, watchdog and main sequence
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #(50000 * 8);
        miscompares++;
        print_verdict();
    end

    initial
    begin
        {nrst, ld, up, dn, rate, over, mism, miss, smp, fs0, fs1} = '0;
        ld_val = 12'h000;
        err = 12'h000;
        tick(3);
        nrst = 1'b1;
        flags(1, `RST_FLAG_N, `RST_FLAG_N);
        chk1(dir, `RST_DIR);
        t_encoder();
        t_overrange();
        t_mismatch();
        t_missing();
        t_track();
        t_excite();
        print_verdict();
    end
endmodule : test_resolver_status_and_encoder_outputs
